// ===== core/tsr_pkg.sv
package tsr_pkg;
  // Command codes of the three registers
  localparam logic [7:0] CMD_STATUS1 = 8'h02;
  localparam logic [7:0] CMD_STATUS2 = 8'h12;
  localparam logic [7:0] CMD_RATE = 8'h0a;
  // Values after reset
  localparam logic [7:0] RATE_RST = 8'h06;
  localparam logic [6:0] ST1_FLAGS_RST = 7'h00;
  localparam logic [6:0] ST2_FLAGS_RST = 7'h00;
  localparam logic BUSY_RST = 1'b1;
  // Read-to-clear fields: status 1 bits 6..0, status 2 bits 7..1
  localparam logic [7:0] ST1_RC_MASK = 8'h7f;
  localparam logic [7:0] ST2_RC_MASK = 8'hfe;
  localparam int BUSY_BIT = 7;
  localparam logic ST2_RSVD_VAL = 1'b0;
  // Rate decode
  localparam logic [2:0] RATE_TOP_CODE = 3'h6;
  localparam logic [2:0] EXT_RES_MAX = 3'h5;
  // Remote-a period at the fastest code, and the clock
  localparam real FAST_PERIOD_S = 0.125;
  localparam real CLK_FREQ_HZ = 250.0e6;
  localparam logic [31:0] FAST_PERIOD_CYC = 32'($rtoi(FAST_PERIOD_S * CLK_FREQ_HZ));
  // Strap sampling waits for the pin synchronisers to fill
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_HIZ = 2'h1;
  localparam logic [1:0] STRAP_VCC = 2'h2;
  localparam logic [6:0] FIXED_ADDR = 7'h18;
  // Index is strap_a * 3 + strap_b
  localparam logic [8:0][6:0] ADDR_MAP = {
    7'h4e, 7'h4d, 7'h4c, 7'h2b, 7'h2a, 7'h29, 7'h1a, 7'h19, 7'h18
  };

  typedef struct packed {
    logic over;
    logic under;
    logic open;
    logic first_ot;
    logic second_ot;
  } tsr_chan_res_t;

  typedef struct packed {
    tsr_chan_res_t loc;
    tsr_chan_res_t rem_a;
    tsr_chan_res_t rem_b;
  } tsr_conv_res_t;

  // Bit 0 local, bit 1 remote a, bit 2 remote b
  typedef struct packed {
    logic [2:0] first_ot;
    logic [2:0] second_ot;
  } tsr_ot_rel_t;

  typedef struct packed {
    logic alert_mask;
    logic run_stop;
    logic ara_disable;
    logic mask_b;
    logic mask_a;
  } tsr_cfg_t;
endpackage

// ===== core/tsr_conv_sched.sv
`timescale 1ns/100ps
`default_nettype none
module tsr_conv_sched #(
  parameter logic [31:0] FAST_CYC = tsr_pkg::FAST_PERIOD_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic soft_rst,
  // Control
  input wire logic run_en,
  input wire logic [2:0] rate_code,
  input wire logic oneshot,
  input wire logic conv_done,
  // Schedule
  output logic conv_start,
  output logic conv_full,
  output logic busy
);
  import tsr_pkg::*;

  logic [31:0] cnt_q;
  logic [31:0] period;
  logic [2:0] code;
  logic run_q;
  logic boot_q;
  logic phase_q;
  logic busy_q;
  logic full_q;
  logic force_full;
  logic expire;

  // Code 7 runs like code 6
  assign code = (rate_code > RATE_TOP_CODE) ? RATE_TOP_CODE : rate_code;
  assign period = FAST_CYC << (RATE_TOP_CODE - code);
  // A run or timer start held off by a busy converter waits; a one-shot request is dropped
  assign force_full = boot_q | (((run_en & ~run_q) | oneshot) & ~busy_q);
  assign expire = run_en & run_q & ~busy_q & (cnt_q == 32'h0);
  assign conv_start = force_full | expire;
  assign conv_full = full_q;
  assign busy = busy_q | boot_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boot_q <= 1'b1;
      run_q <= 1'b0;
    end else if (soft_rst) begin
      boot_q <= 1'b1;
      run_q <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      if (!busy_q) begin
        run_q <= run_en;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
      phase_q <= 1'b0;
      full_q <= 1'b1;
    end else if (soft_rst) begin
      cnt_q <= 32'h0;
      phase_q <= 1'b0;
      full_q <= 1'b1;
    end else if (conv_start) begin
      cnt_q <= period - 32'h1;
      phase_q <= force_full ? 1'b1 : ~phase_q;
      full_q <= force_full | ~phase_q;
    end else if (run_en && cnt_q != 32'h0) begin
      cnt_q <= cnt_q - 32'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (soft_rst) begin
      busy_q <= 1'b0;
    end else if (conv_start) begin
      busy_q <= 1'b1;
    end else if (conv_done) begin
      busy_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== core/tsr_status_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - After reset all status flags read zero; busy bit reads one.
// - A completed status read clears status 1 bits 6..0 and status 2 bits 7..1.
// - Alert follows alert flags; read clears both; next conversion re-sets.
// - Over-temperature flags clear on read even if the fault remains.
// - Status reads never release the over-temperature pins.
// - Pin fault ends on cooling or on new thresholds or hysteresis.
// - Status 1 bit 7 shows converter busy; reads do not clear it.
// - Status 1 bits 6..2: local and remote-a limit and open flags.
// - Status 1 bits 1 and 0: remote-a and local first threshold.
// - Status 2 bits 7..5 second thresholds, bit 1 remote-b, bit 0 reserved.
// - Status 2 bits 4..2: remote-b over, under and open diode.
// - Reset pin high restores defaults and resamples address straps.
// - Rate register paces conversions only while running freely.
// - Rate register resets to 06h: local/remote-b 4 Hz, remote-a 8 Hz.
// - Codes 0..6 halve the period from 8 s; code 7 acts as 6.
// - Only the low 3 rate bits are decoded; host writes zeros above.
// - Extended resolution only at rate codes 05h and below.
// - Results arrive one conversion time after any kind of start.
// - Fixed variant answers 0011000; strap variant picks one of nine.
// - Straps are sampled at power-on and reset pin only, then held.
// - Alert response is answered while an alert is pending.
// - Alert latches; cleared by status read or alert response.
// - Pin releases below threshold minus hysteresis.
// - Alert mask bit blocks alert assertion.
module tsr_status_ctrl #(
  parameter logic [31:0] FAST_PERIOD_CYC = tsr_pkg::FAST_PERIOD_CYC,
  parameter bit FIXED_ADDR_PART = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pins
  input wire logic reset_pin,
  input wire logic hardware_standby_pin_n,
  input wire logic [1:0] address_strap_a,
  input wire logic [1:0] address_strap_b,
  input wire logic smb_scl_in,
  input wire logic smb_sda_in,
  output logic alert_out,
  output logic alert_oe,
  output logic first_overtemp_output_out,
  output logic first_overtemp_output_oe,
  output logic second_overtemp_output_out,
  output logic second_overtemp_output_oe,
  // Register port from the framing engine
  input wire logic [7:0] reg_cmd,
  input wire logic reg_wr_stb,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_stb,
  input wire logic reg_rd_shifted,
  output logic [7:0] reg_rd_data,
  input wire logic ara_done,
  output logic ara_pending,
  output logic [6:0] slave_addr,
  // Configuration and converter
  input wire tsr_pkg::tsr_cfg_t cfg,
  input wire logic oneshot,
  input wire logic conv_done,
  input wire tsr_pkg::tsr_conv_res_t conv_res,
  input wire tsr_pkg::tsr_ot_rel_t ot_rel,
  output logic conv_start,
  output logic conv_full,
  output logic ext_res
);
  import tsr_pkg::*;

  logic [1:0] rst_sync_q;
  logic [1:0] hardware_standby_pin_sync_q;
  logic [1:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic [1:0] stra_sync_q [2];
  logic [1:0] strb_sync_q [2];
  logic soft_rst;
  logic stop_det;
  logic run_en;
  logic busy;
  logic [6:0] st1_q;
  logic [6:0] st2_q;
  logic [6:0] set1;
  logic [6:0] set2;
  logic [6:0] clr1_q;
  logic [6:0] clr2_q;
  logic pend_q;
  logic fire;
  logic alert_q;
  logic alert_src;
  logic [7:0] rate_q;
  logic ext_res_q;
  logic [7:0] rd_q;
  logic [2:0] first_ot_q;
  logic [2:0] second_ot_q;
  logic [2:0] first_set;
  logic [2:0] second_set;
  logic [1:0] samp_cnt_q;
  logic [6:0] addr_q;
  logic [1:0] sa;
  logic [1:0] sb;
  logic [3:0] addr_idx;

  // Pins from outside the clock domain pass two flops first
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
      hardware_standby_pin_sync_q <= 2'h3;
      scl_sync_q <= 2'h3;
      sda_sync_q <= 3'h7;
      stra_sync_q[0] <= 2'h0;
      stra_sync_q[1] <= 2'h0;
      strb_sync_q[0] <= 2'h0;
      strb_sync_q[1] <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], reset_pin};
      hardware_standby_pin_sync_q <= {hardware_standby_pin_sync_q[0], hardware_standby_pin_n};
      scl_sync_q <= {scl_sync_q[0], smb_scl_in};
      sda_sync_q <= {sda_sync_q[1:0], smb_sda_in};
      stra_sync_q[0] <= address_strap_a;
      stra_sync_q[1] <= stra_sync_q[0];
      strb_sync_q[0] <= address_strap_b;
      strb_sync_q[1] <= strb_sync_q[0];
    end
  end

  assign soft_rst = rst_sync_q[1];
  // Stop condition: data rises while the bus clock is high
  assign stop_det = scl_sync_q[1] & sda_sync_q[1] & ~sda_sync_q[2];
  assign run_en = ~cfg.run_stop & hardware_standby_pin_sync_q[1];

  tsr_conv_sched #(
    .FAST_CYC(FAST_PERIOD_CYC)
  ) u_sched (
    .mclk(mclk),
    .rst_n(rst_n),
    .soft_rst(soft_rst),
    .run_en(run_en),
    .rate_code(rate_q[2:0]),
    .oneshot(oneshot),
    .conv_done(conv_done),
    .conv_start(conv_start),
    .conv_full(conv_full),
    .busy(busy)
  );

  // Partial conversions only refresh remote a
  always_comb begin
    set1 = 7'h0;
    set2 = 7'h0;
    if (conv_done) begin
      set1 = {conv_res.loc.over & conv_full, conv_res.loc.under & conv_full,
              conv_res.rem_a.over, conv_res.rem_a.under, conv_res.rem_a.open,
              conv_res.rem_a.first_ot, conv_res.loc.first_ot & conv_full};
      set2 = {conv_res.loc.second_ot & conv_full,
              conv_res.rem_b.second_ot & conv_full,
              conv_res.rem_a.second_ot,
              conv_res.rem_b.over & conv_full, conv_res.rem_b.under & conv_full,
              conv_res.rem_b.open & conv_full,
              conv_res.rem_b.first_ot & conv_full};
    end
  end

  // Clearing waits for the stop that ends the read
  assign fire = stop_det & pend_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clr1_q <= 7'h0;
      clr2_q <= 7'h0;
      pend_q <= 1'b0;
    end else if (soft_rst || fire) begin
      clr1_q <= 7'h0;
      clr2_q <= 7'h0;
      pend_q <= 1'b0;
    end else if (reg_rd_shifted) begin
      // Only bits that were actually shifted out are cleared
      if (reg_cmd == CMD_STATUS1) begin
        clr1_q <= clr1_q | rd_q[6:0];
        pend_q <= 1'b1;
      end else if (reg_cmd == CMD_STATUS2) begin
        clr2_q <= clr2_q | rd_q[7:1];
        pend_q <= 1'b1;
      end
    end
  end

  // Set wins over clear, so an event at the stop is kept
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st1_q <= ST1_FLAGS_RST;
      st2_q <= ST2_FLAGS_RST;
    end else if (soft_rst) begin
      st1_q <= ST1_FLAGS_RST;
      st2_q <= ST2_FLAGS_RST;
    end else begin
      st1_q <= (st1_q & ~(fire ? clr1_q : 7'h0)) | set1;
      st2_q <= (st2_q & ~(fire ? clr2_q : 7'h0)) | set2;
    end
  end

  // Channel masks apply to limit and open faults only
  assign alert_src = ~cfg.alert_mask & conv_done &
    ((conv_full & (conv_res.loc.over | conv_res.loc.under)) |
     (~cfg.mask_a & (conv_res.rem_a.over | conv_res.rem_a.under | conv_res.rem_a.open)) |
     (~cfg.mask_b & conv_full &
      (conv_res.rem_b.over | conv_res.rem_b.under | conv_res.rem_b.open)));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alert_q <= 1'b0;
    end else if (soft_rst) begin
      alert_q <= 1'b0;
    end else if (alert_src) begin
      alert_q <= 1'b1;
    end else if (fire || ara_done) begin
      alert_q <= 1'b0;
    end
  end

  assign alert_out = 1'b0;
  assign alert_oe = alert_q;
  assign ara_pending = alert_q & ~cfg.ara_disable;

  // Pins set from a conversion, released only by the comparator inputs
  assign first_set = conv_done ? {conv_res.rem_b.first_ot & conv_full,
    conv_res.rem_a.first_ot, conv_res.loc.first_ot & conv_full} : 3'h0;
  assign second_set = conv_done ? {conv_res.rem_b.second_ot & conv_full,
    conv_res.rem_a.second_ot, conv_res.loc.second_ot & conv_full} : 3'h0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      first_ot_q <= 3'h0;
      second_ot_q <= 3'h0;
    end else if (soft_rst) begin
      first_ot_q <= 3'h0;
      second_ot_q <= 3'h0;
    end else begin
      first_ot_q <= (first_ot_q & ~ot_rel.first_ot) | first_set;
      second_ot_q <= (second_ot_q & ~ot_rel.second_ot) | second_set;
    end
  end

  assign first_overtemp_output_out = 1'b0;
  assign first_overtemp_output_oe = |first_ot_q;
  assign second_overtemp_output_out = 1'b0;
  assign second_overtemp_output_oe = |second_ot_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rate_q <= RATE_RST;
      ext_res_q <= 1'b0;
    end else if (soft_rst) begin
      rate_q <= RATE_RST;
      ext_res_q <= 1'b0;
    end else begin
      if (reg_wr_stb && reg_cmd == CMD_RATE) begin
        rate_q <= reg_wr_data;
      end
      ext_res_q <= (rate_q[2:0] <= EXT_RES_MAX);
    end
  end

  assign ext_res = ext_res_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 8'h0;
    end else if (reg_rd_stb) begin
      case (reg_cmd)
        CMD_STATUS1: rd_q <= {busy, st1_q};
        CMD_STATUS2: rd_q <= {st2_q, ST2_RSVD_VAL};
        CMD_RATE: rd_q <= rate_q;
        default: rd_q <= 8'h0;
      endcase
    end
  end

  assign reg_rd_data = rd_q;

  // Strap decode; an unknown code is taken as high
  assign sa = (stra_sync_q[1] > STRAP_VCC) ? STRAP_VCC : stra_sync_q[1];
  assign sb = (strb_sync_q[1] > STRAP_VCC) ? STRAP_VCC : strb_sync_q[1];
  assign addr_idx = 4'(sa) * 4'h3 + 4'(sb);

  // Latched so the three-state detectors can stay off afterwards
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      samp_cnt_q <= STRAP_SETTLE;
      addr_q <= FIXED_ADDR;
    end else if (soft_rst) begin
      samp_cnt_q <= STRAP_SETTLE;
    end else if (samp_cnt_q != 2'h0) begin
      samp_cnt_q <= samp_cnt_q - 2'h1;
      if (samp_cnt_q == 2'h1) begin
        addr_q <= FIXED_ADDR_PART ? FIXED_ADDR : ADDR_MAP[addr_idx];
      end
    end
  end

  assign slave_addr = addr_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || soft_rst);

  sequence s_read_close;
    stop_det && pend_q && !conv_done;
  endsequence

  sequence s_fault_conv;
    conv_done && alert_src;
  endsequence

  a_busy_follow: assert property (
    conv_start |=> busy
  ) else $error("busy not set after conversion start");
  a_busy_drop: assert property (
    (conv_done && !conv_start && !conv_full) ##1 !conv_start |-> !busy
  ) else $error("busy still set after conversion end");
  a_read_clears: assert property (
    s_read_close |=> (st1_q & $past(clr1_q)) == 7'h0
  ) else $error("status 1 flags not cleared by completed read");
  a_event_kept: assert property (
    (set1 != 7'h0) |=> (st1_q & $past(set1)) == $past(set1)
  ) else $error("new status event lost");
  a_alert_sets: assert property (
    s_fault_conv |=> alert_oe ##1 (alert_oe || $past(fire) || $past(ara_done))
  ) else $error("alert not raised after fault conversion");
  a_alert_clear: assert property (
    (s_read_close or (ara_done && !alert_src)) |=> !alert_oe
  ) else $error("alert not cleared by read or alert response");
  a_ot_pin_hold: assert property (
    (first_ot_q != 3'h0 && (first_ot_q & ot_rel.first_ot) == 3'h0) |=>
      first_overtemp_output_oe
  ) else $error("first pin released without cooling");
  a_ot_pin_free: assert property (
    ((first_ot_q & ~ot_rel.first_ot) == 3'h0 && first_set == 3'h0) |=>
      !first_overtemp_output_oe
  ) else $error("first pin held after release");
  a_ext_res: assert property (
    (reg_wr_stb && reg_cmd == CMD_RATE) |=> ##1
      ext_res == ($past(reg_wr_data[2:0], 2) <= EXT_RES_MAX)
  ) else $error("resolution mode does not follow rate code");
  a_addr_latched: assert property (
    (samp_cnt_q == 2'h0) |=> $stable(slave_addr)
  ) else $error("slave address changed outside reset");
endmodule
`default_nettype wire

// ===== verif/tsr_smb_host.sv
`timescale 1ns/100ps
`default_nettype none
// Host side of the bus: closes a status read with a short START/STOP frame.
// The lines rest high between frames, as the pull-ups hold them.
module tsr_smb_host (
  // Control
  input wire logic go,
  output logic active,
  // Bus lines
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    active = 1'b0;
    forever begin
      @(posedge go);
      active = 1'b1;
      sda = 1'b0;
      #32 scl = 1'b0;
      #32 scl = 1'b1;
      // Data rising while the clock is high ends the transfer
      #32 sda = 1'b1;
      #32 active = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_tsr_status_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_tsr_status_ctrl;
  import tsr_pkg::*;
  localparam int FAST = 40;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin = 1'b0;
  logic hardware_standby_pin_n = 1'b1;
  logic [1:0] address_strap_a = STRAP_GND;
  logic [1:0] address_strap_b = STRAP_GND;
  logic smb_scl_in, smb_sda_in, active;
  logic go = 1'b0;
  logic alert_out, alert_oe, ara_pending, conv_start, conv_full, ext_res, conv_done;
  logic first_overtemp_output_out, first_overtemp_output_oe;
  logic second_overtemp_output_out, second_overtemp_output_oe;
  logic [7:0] reg_cmd = 8'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic [7:0] reg_rd_data;
  logic reg_wr_stb = 1'b0;
  logic reg_rd_stb = 1'b0;
  logic reg_rd_shifted = 1'b0;
  logic ara_done = 1'b0;
  logic oneshot = 1'b0;
  logic [6:0] slave_addr;
  tsr_cfg_t cfg = tsr_cfg_t'(5'h08);
  tsr_conv_res_t conv_res = '0;
  tsr_ot_rel_t ot_rel = '0;
  logic [3:0] ccnt;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  tsr_status_ctrl #(.FAST_PERIOD_CYC(32'(FAST)), .FIXED_ADDR_PART(1'b0)) i_tsr_status_ctrl (
    .mclk, .rst_n, .reset_pin, .hardware_standby_pin_n, .address_strap_a, .address_strap_b,
    .smb_scl_in, .smb_sda_in, .alert_out, .alert_oe, .first_overtemp_output_out,
    .first_overtemp_output_oe, .second_overtemp_output_out, .second_overtemp_output_oe,
    .reg_cmd, .reg_wr_stb, .reg_wr_data, .reg_rd_stb, .reg_rd_shifted, .reg_rd_data,
    .ara_done, .ara_pending, .slave_addr, .cfg, .oneshot, .conv_done, .conv_res, .ot_rel,
    .conv_start, .conv_full, .ext_res
  );

  tsr_smb_host i_tsr_smb_host (.go, .active, .scl(smb_scl_in), .sda(smb_sda_in));

  initial begin
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) cyc <= cyc + 1;

  // Converter stand-in: every start finishes eight cycles later
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) ccnt <= 4'h0;
    else if (conv_start) ccnt <= 4'h8;
    else if (ccnt != 4'h0) ccnt <= ccnt - 4'h1;
  end
  assign conv_done = (ccnt == 4'h1);

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    check({7'h0, got}, {7'h0, exp});
  endtask

  task automatic rd(input logic [7:0] cmd, output logic [7:0] d);
    @(posedge mclk);
    reg_cmd <= cmd;
    reg_rd_stb <= 1'b1;
    @(posedge mclk);
    reg_rd_stb <= 1'b0;
    @(negedge mclk);
    d = reg_rd_data;
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    @(posedge mclk);
    reg_cmd <= cmd;
    reg_wr_data <= d;
    reg_wr_stb <= 1'b1;
    @(posedge mclk);
    reg_wr_stb <= 1'b0;
  endtask

  // Read that is shifted out and closed by a STOP, so it clears
  task automatic rdc(input logic [7:0] cmd, output logic [7:0] d);
    int n;
    rd(cmd, d);
    @(posedge mclk);
    reg_rd_shifted <= 1'b1;
    @(posedge mclk);
    reg_rd_shifted <= 1'b0;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (active !== 1'b0 && n < 100);
  endtask

  task automatic conv;
    @(posedge mclk);
    oneshot <= 1'b1;
    @(posedge mclk);
    oneshot <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask

  task automatic wait_start(output int t, output logic f);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (conv_start !== 1'b1 && n < 2000);
    t = cyc;
    @(negedge mclk);
    f = conv_full;
  endtask

  // Status 1 bits 6..0 then status 2 bits 7..0
  function automatic logic [14:0] exp_st(input tsr_conv_res_t r);
    return {r.loc.over, r.loc.under, r.rem_a.over, r.rem_a.under, r.rem_a.open,
      r.rem_a.first_ot, r.loc.first_ot, r.loc.second_ot, r.rem_b.second_ot,
      r.rem_a.second_ot, r.rem_b.over, r.rem_b.under, r.rem_b.open, r.rem_b.first_ot, 1'b0};
  endfunction

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    end_of_test();
  end

  initial begin
    logic [7:0] d;
    logic [14:0] e;
    int t1, t2, n, per;
    logic f1, f2;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(CMD_STATUS1, d);
    check(d, 8'h80);
    rd(CMD_STATUS2, d);
    check(d, 8'h00);
    rd(CMD_RATE, d);
    check(d, 8'h06);
    repeat (12) @(posedge mclk);
    rd(CMD_STATUS1, d);
    check(d, 8'h00);
    check({1'b0, slave_addr}, 8'h18);
    $display("test reset done");

    // One fault per conversion; trends are never read from flags
    for (int i = 0; i < 15; i++) begin
      conv_res <= tsr_conv_res_t'(15'h1 << i);
      conv();
      e = exp_st(tsr_conv_res_t'(15'h1 << i));
      rd(CMD_STATUS1, d);
      check(d, {1'b0, e[14:8]});
      rd(CMD_STATUS2, d);
      check(d, e[7:0]);
      chk1(alert_oe, |(e & 15'h7c1c));
      conv_res <= '0;
      rdc(CMD_STATUS1, d);
      rdc(CMD_STATUS2, d);
      rd(CMD_STATUS1, d);
      check(d, 8'h00);
      rd(CMD_STATUS2, d);
      check(d, 8'h00);
      chk1(alert_oe, 1'b0);
      chk1(first_overtemp_output_oe, |{e[9:8], e[1]});
      chk1(second_overtemp_output_oe, |e[7:5]);
      ot_rel <= '1;
      repeat (3) @(posedge mclk);
      chk1(first_overtemp_output_oe | second_overtemp_output_oe, 1'b0);
      ot_rel <= '0;
    end
    $display("test flags done");

    conv_res <= tsr_conv_res_t'(15'h4000);
    conv();
    chk1(ara_pending, 1'b1);
    rdc(CMD_STATUS1, d);
    check(d, 8'h40);
    chk1(alert_oe, 1'b0);
    conv();
    chk1(alert_oe, 1'b1);
    @(posedge mclk);
    ara_done <= 1'b1;
    @(posedge mclk);
    ara_done <= 1'b0;
    @(negedge mclk);
    chk1(alert_oe | ara_pending, 1'b0);
    cfg <= tsr_cfg_t'(5'h18);
    conv();
    chk1(alert_oe, 1'b0);
    conv_res <= '0;
    cfg <= tsr_cfg_t'(5'h08);
    rdc(CMD_STATUS1, d);
    $display("test alert done");

    for (int c = 0; c < 8; c++) begin
      wr(CMD_RATE, 8'(c));
      rd(CMD_RATE, d);
      check(d, 8'(c));
      chk1(ext_res, c <= 5);
    end
    wr(CMD_RATE, 8'hf2);
    rd(CMD_RATE, d);
    chk1(ext_res, 1'b1);
    // Codes 6, 4 and 7 in turn
    for (int k = 0; k < 3; k++) begin
      per = (k == 1) ? FAST << 2 : FAST;
      wr(CMD_RATE, (k == 1) ? 8'h04 : ((k == 0) ? 8'h06 : 8'h07));
      cfg <= tsr_cfg_t'(5'h00);
      wait_start(t1, f1);
      wait_start(t1, f1);
      wait_start(t2, f2);
      check(8'(t2 - t1), 8'(per));
      chk1(f1 ^ f2, 1'b1);
      cfg <= tsr_cfg_t'(5'h08);
      repeat (20) @(posedge mclk);
    end
    n = 0;
    repeat (400) begin
      @(posedge mclk);
      if (conv_start === 1'b1) n++;
    end
    check(8'(n), 8'h00);
    $display("test rate done");

    address_strap_a <= STRAP_VCC;
    address_strap_b <= STRAP_HIZ;
    repeat (10) @(posedge mclk);
    check({1'b0, slave_addr}, 8'h18);
    reset_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    reset_pin <= 1'b0;
    repeat (10) @(posedge mclk);
    check({1'b0, slave_addr}, 8'h4d);
    rd(CMD_RATE, d);
    check(d, 8'h06);
    $display("test reset pin done");
    end_of_test();
  end
endmodule
`default_nettype wire
